// ==== srf_defines.vh ====
// Contract
// - Station number 00 to 99 identifies unit
// - Verbose report: station, mnemonic, right-justified value
// - Verbose prints pause 400 ms between values
// - Terse report sends value only, no pause
// - Content code 01 timer, 02 presets, 03 both
// - Clear timer after capture when option set (code clears only on a print, not on a transmit)
// - Factory restore returns all settings to defaults
// - Serial reporting exists only in dual-preset builds
// - Speeds 1200 to 9600, parity or 8 bits
// - Frame: start, 7/8 data, parity, stop
// - Wait 100 ms before sending a report
`ifndef SRF_DEFINES_VH
`define SRF_DEFINES_VH

`define SRF_ADDR_CONFIG      12'h000
`define SRF_ADDR_COMMAND     12'h004
`define SRF_ADDR_STATUS      12'h008

`define SRF_CFG_STN_LSB      0
`define SRF_CFG_STN_MSB      6
`define SRF_CFG_TERSE        7
`define SRF_CFG_CONT_LSB     8
`define SRF_CFG_CONT_MSB     9
`define SRF_CFG_CLEAR        10
`define SRF_CFG_LINE_LSB     12
`define SRF_CFG_LINE_MSB     15

`define SRF_CMD_PRINT        0
`define SRF_CMD_XMIT         1
`define SRF_CMD_ID_LSB       2
`define SRF_CMD_ID_MSB       3
`define SRF_CMD_RESTORE      8

`define SRF_ST_BUSY          0
`define SRF_ST_WAIT          1
`define SRF_ST_GAP           2
`define SRF_ST_REFUSED       3

`define SRF_STN_MAX          7'h63
`define SRF_LINE_MAX         4'hB
`define SRF_DEF_STN          7'h00
`define SRF_DEF_TERSE        1'b0
`define SRF_DEF_CONT         2'h3
`define SRF_DEF_CLEAR        1'b0
`define SRF_DEF_LINE         4'h9

`define SRF_CONT_TIMER       2'h1
`define SRF_CONT_PRESETS     2'h2
`define SRF_CONT_BOTH        2'h3

`define SRF_ID_TIMER         2'h0
`define SRF_ID_P1            2'h1
`define SRF_ID_P2            2'h2

`define SRF_CLK_PERIOD_PS    5000
`define SRF_MS_PS            1000000000
`define SRF_MS_CYCLES        (`SRF_MS_PS / `SRF_CLK_PERIOD_PS)
`define SRF_START_DELAY_MS   100
`define SRF_VALUE_GAP_MS     400

`define SRF_IDX_VALUE        4'h7
`define SRF_IDX_LAST         4'hE

`endif

// ==== srf_skid2.v ====
`timescale 1ns/1ps
module srf_skid2 #(
    parameter WIDTH = 8
) (
    input  wire             sys_clk_in,
    input  wire             sys_rst_in,
    input  wire             in_valid_in,
    input  wire [WIDTH-1:0] in_data_in,
    output reg              in_ready_out,
    output reg              out_valid_out,
    output reg  [WIDTH-1:0] out_data_out,
    input  wire             out_ready_in
);
    // Head entry sits in the output flops so the consumer sees a registered word
    reg [WIDTH-1:0] hold_r;
    reg             hold_valid_r;
    wire            push = in_valid_in && !hold_valid_r;
    wire            pop  = out_ready_in && out_valid_out;

    always @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            out_valid_out <= 1'b0;
            out_data_out  <= {WIDTH{1'b0}};
            hold_valid_r  <= 1'b0;
            hold_r        <= {WIDTH{1'b0}};
            in_ready_out  <= 1'b1;
        end else begin
            if (pop) begin
                if (hold_valid_r) begin
                    out_data_out <= hold_r;
                    hold_valid_r <= 1'b0;
                    in_ready_out <= 1'b1;
                end else begin
                    out_data_out  <= in_data_in;
                    out_valid_out <= push;
                end
            end else if (push) begin
                if (!out_valid_out) begin
                    out_data_out  <= in_data_in;
                    out_valid_out <= 1'b1;
                end else begin
                    hold_r       <= in_data_in;
                    hold_valid_r <= 1'b1;
                    in_ready_out <= 1'b0;
                end
            end
        end
    end
endmodule // srf_skid2

// ==== srf_formatter.v ====
// Register access over APB and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "srf_defines.vh"
module srf_formatter #(
    parameter        HAS_SERIAL = 1,
    parameter [31:0] MS_CYCLES  = `SRF_MS_CYCLES,
    parameter [8:0]  START_MS   = `SRF_START_DELAY_MS,
    parameter [8:0]  GAP_MS     = `SRF_VALUE_GAP_MS
) (
    input  wire        sys_clk_in,
    input  wire        sys_rst_in,
    input  wire        psel_in,
    input  wire        penable_in,
    input  wire        pwrite_in,
    input  wire [11:0] paddr_in,
    input  wire [31:0] pwdata_in,
    output reg  [31:0] prdata_out,
    output reg         pready_out,
    output reg         pslverr_out,
    input  wire [23:0] timer_bcd_in,
    input  wire [23:0] preset1_bcd_in,
    input  wire [23:0] preset2_bcd_in,
    input  wire        user_print_in,
    output reg         timer_clear_out,
    output reg  [3:0]  line_cfg_out,
    output wire        tx_valid_out,
    output wire [7:0]  tx_data_out,
    input  wire        tx_ready_in
);
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_WAIT = 3'h1;
    localparam [2:0] ST_LOAD = 3'h2;
    localparam [2:0] ST_SEND = 3'h3;
    localparam [2:0] ST_GAP  = 3'h4;

    reg  [6:0]  stn_r;
    reg         terse_r;
    reg  [1:0]  cont_r;
    reg         clear_r;
    reg         refused_r;
    reg  [2:0]  state_r;
    reg  [1:0]  item_r;
    reg         print_r;
    reg  [3:0]  idx_r;
    reg  [23:0] value_r;
    reg  [31:0] div_r;
    reg  [8:0]  ms_r;
    reg         usr_meta_r;
    reg         usr_sync_r;
    reg  [7:0]  char_nxt;
    wire        buf_ready;
    wire        send_ok;
    wire        wr_en;
    wire        rd_en;
    wire        ms_tick;
    wire        cmd_print;
    wire        cmd_xmit;
    wire        cmd_start;
    wire        usr_start;
    wire [1:0]  cmd_id;
    wire [31:0] cfg_word;
    wire [31:0] st_word;
    wire [6:0]  stn_tens = stn_r / 7'hA;
    wire [6:0]  stn_ones = stn_r % 7'hA;

    function [7:0] digit_char;
        input [3:0] d;
        begin
            digit_char = {4'h3, d};
        end
    endfunction

    // Leading zeros become blanks; the last digit always prints
    function [7:0] value_char;
        input [23:0] v;
        input [2:0]  pos;
        integer k;
        reg     lead;
        reg [3:0] d;
        begin
            lead = 1'b1;
            d = 4'h0;
            value_char = 8'h20;
            for (k = 0; k < 6; k = k + 1) begin
                d = v[23 - 4*k -: 4];
                if (d != 4'h0 || k == 5) begin
                    lead = 1'b0;
                end
                if (k == pos) begin
                    value_char = lead ? 8'h20 : digit_char(d);
                end
            end
        end
    endfunction

    function [7:0] mnem_char;
        input [1:0] id;
        input [1:0] pos;
        begin
            mnem_char = 8'h20;
            if (id == `SRF_ID_TIMER) begin
                mnem_char = (pos == 2'h0) ? 8'h54 : (pos == 2'h1) ? 8'h4D : 8'h52;
            end else if (pos == 2'h0) begin
                mnem_char = 8'h50;
            end else if (pos == 2'h1) begin
                mnem_char = (id == `SRF_ID_P1) ? 8'h31 : 8'h32;
            end
        end
    endfunction

    // Next item of a print; 2'h3 means the print is finished
    function [1:0] next_item;
        input [1:0] cur;
        input [1:0] cont;
        begin
            if (cur == `SRF_ID_TIMER) begin
                next_item = (cont == `SRF_CONT_BOTH) ? `SRF_ID_P1 : 2'h3;
            end else if (cur == `SRF_ID_P1) begin
                next_item = `SRF_ID_P2;
            end else begin
                next_item = 2'h3;
            end
        end
    endfunction

    assign wr_en     = psel_in && penable_in && pready_out && pwrite_in;
    assign rd_en     = psel_in && penable_in && !pready_out && !pwrite_in;
    assign cmd_id    = pwdata_in[`SRF_CMD_ID_MSB:`SRF_CMD_ID_LSB];
    assign cmd_print = wr_en && paddr_in == `SRF_ADDR_COMMAND && pwdata_in[`SRF_CMD_PRINT];
    assign cmd_xmit  = wr_en && paddr_in == `SRF_ADDR_COMMAND && pwdata_in[`SRF_CMD_XMIT]
                       && !pwdata_in[`SRF_CMD_PRINT];
    // Serial reporting only answers in the dual-preset build with the port fitted
    assign cmd_start = (HAS_SERIAL != 0) && state_r == ST_IDLE
                       && (cmd_print || (cmd_xmit && cmd_id != 2'h3));
    assign usr_start = (HAS_SERIAL != 0) && state_r == ST_IDLE && usr_sync_r
                       && !cmd_print && !cmd_xmit;
    assign ms_tick   = div_r == MS_CYCLES - 32'h1;
    assign send_ok   = state_r == ST_SEND && buf_ready;

    assign cfg_word = {16'h0, line_cfg_out, 1'b0, clear_r, cont_r, terse_r, stn_r};
    assign st_word  = {28'h0, refused_r, state_r == ST_GAP, state_r == ST_WAIT,
                       state_r != ST_IDLE};

    always @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            usr_meta_r <= 1'b0;
            usr_sync_r <= 1'b0;
        end else begin
            usr_meta_r <= user_print_in;
            usr_sync_r <= usr_meta_r;
        end
    end

    // APB slave: one wait state, answer registered with pready
    always @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out  <= 32'h0;
        end else begin
            pready_out  <= psel_in && penable_in && !pready_out;
            pslverr_out <= psel_in && penable_in && !pready_out
                           && paddr_in != `SRF_ADDR_CONFIG
                           && paddr_in != `SRF_ADDR_COMMAND
                           && paddr_in != `SRF_ADDR_STATUS;
            if (rd_en) begin
                if (HAS_SERIAL == 0) begin
                    prdata_out <= 32'h0;
                end else if (paddr_in == `SRF_ADDR_CONFIG) begin
                    prdata_out <= cfg_word;
                end else if (paddr_in == `SRF_ADDR_STATUS) begin
                    prdata_out <= st_word;
                end else begin
                    prdata_out <= 32'h0;
                end
            end
        end
    end

    // Out-of-range settings are ignored field by field rather than clipped
    always @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            stn_r        <= `SRF_DEF_STN;
            terse_r      <= `SRF_DEF_TERSE;
            cont_r       <= `SRF_DEF_CONT;
            clear_r      <= `SRF_DEF_CLEAR;
            line_cfg_out <= `SRF_DEF_LINE;
            refused_r    <= 1'b0;
        end else begin
            if (wr_en && paddr_in == `SRF_ADDR_COMMAND && pwdata_in[`SRF_CMD_RESTORE]) begin
                stn_r        <= `SRF_DEF_STN;
                terse_r      <= `SRF_DEF_TERSE;
                cont_r       <= `SRF_DEF_CONT;
                clear_r      <= `SRF_DEF_CLEAR;
                line_cfg_out <= `SRF_DEF_LINE;
            end else if (wr_en && paddr_in == `SRF_ADDR_CONFIG) begin
                if (pwdata_in[`SRF_CFG_STN_MSB:`SRF_CFG_STN_LSB] <= `SRF_STN_MAX) begin
                    stn_r <= pwdata_in[`SRF_CFG_STN_MSB:`SRF_CFG_STN_LSB];
                end
                terse_r <= pwdata_in[`SRF_CFG_TERSE];
                if (pwdata_in[`SRF_CFG_CONT_MSB:`SRF_CFG_CONT_LSB] != 2'h0) begin
                    cont_r <= pwdata_in[`SRF_CFG_CONT_MSB:`SRF_CFG_CONT_LSB];
                end
                clear_r <= pwdata_in[`SRF_CFG_CLEAR];
                if (pwdata_in[`SRF_CFG_LINE_MSB:`SRF_CFG_LINE_LSB] <= `SRF_LINE_MAX) begin
                    line_cfg_out <= pwdata_in[`SRF_CFG_LINE_MSB:`SRF_CFG_LINE_LSB];
                end
            end
            // A refusal in the clearing cycle still sets the flag
            if ((cmd_print || cmd_xmit) && !cmd_start) begin
                refused_r <= 1'b1;
            end else if (wr_en && paddr_in == `SRF_ADDR_STATUS
                         && pwdata_in[`SRF_ST_REFUSED]) begin
                refused_r <= 1'b0;
            end
        end
    end

    // Character at index: 0-1 station, 3-5 mnemonic, 7-12 value, 13-14 CR LF
    always @* begin
        char_nxt = 8'h20;
        if (idx_r == 4'h0) begin
            char_nxt = digit_char(stn_tens[3:0]);
        end else if (idx_r == 4'h1) begin
            char_nxt = digit_char(stn_ones[3:0]);
        end else if (idx_r >= 4'h3 && idx_r <= 4'h5) begin
            char_nxt = mnem_char(item_r, idx_r[1:0] - 2'h3);
        end else if (idx_r >= `SRF_IDX_VALUE && idx_r <= 4'hC) begin
            char_nxt = value_char(value_r, idx_r[2:0] - 3'h7);
        end else if (idx_r == 4'hD) begin
            char_nxt = 8'h0D;
        end else if (idx_r == `SRF_IDX_LAST) begin
            char_nxt = 8'h0A;
        end
    end

    always @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state_r         <= ST_IDLE;
            item_r          <= `SRF_ID_TIMER;
            print_r         <= 1'b0;
            idx_r           <= 4'h0;
            value_r         <= 24'h0;
            div_r           <= 32'h0;
            ms_r            <= 9'h0;
            timer_clear_out <= 1'b0;
        end else begin
            timer_clear_out <= 1'b0;
            // Pause counts only once the last character has left the buffer,
            // so a stalled line cannot shorten it
            div_r <= (ms_tick || !(state_r == ST_WAIT || (state_r == ST_GAP && !tx_valid_out)))
                     ? 32'h0 : div_r + 32'h1;
            case (state_r)
                ST_IDLE: begin
                    ms_r <= 9'h0;
                    if (cmd_start || usr_start) begin
                        print_r <= cmd_print || usr_start;
                        if (cmd_xmit) begin
                            item_r <= cmd_id;
                        end else if ((usr_start ? cont_r : cont_r) == `SRF_CONT_PRESETS) begin
                            item_r <= `SRF_ID_P1;
                        end else begin
                            item_r <= `SRF_ID_TIMER;
                        end
                        state_r <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (ms_tick) begin
                        ms_r <= ms_r + 9'h1;
                        if (ms_r + 9'h1 >= START_MS) begin
                            ms_r    <= 9'h0;
                            state_r <= ST_LOAD;
                        end
                    end
                end
                ST_LOAD: begin
                    value_r <= (item_r == `SRF_ID_TIMER) ? timer_bcd_in :
                               (item_r == `SRF_ID_P1) ? preset1_bcd_in : preset2_bcd_in;
                    if (print_r && clear_r && item_r == `SRF_ID_TIMER) begin
                        timer_clear_out <= 1'b1;
                    end
                    idx_r   <= terse_r ? `SRF_IDX_VALUE : 4'h0;
                    state_r <= ST_SEND;
                end
                ST_SEND: begin
                    if (send_ok) begin
                        idx_r <= idx_r + 4'h1;
                        if (idx_r == `SRF_IDX_LAST) begin
                            if (!print_r || next_item(item_r, cont_r) == 2'h3) begin
                                state_r <= ST_IDLE;
                            end else begin
                                item_r  <= next_item(item_r, cont_r);
                                state_r <= terse_r ? ST_LOAD : ST_GAP;
                            end
                        end
                    end
                end
                ST_GAP: begin
                    if (ms_tick) begin
                        ms_r <= ms_r + 9'h1;
                        if (ms_r + 9'h1 >= GAP_MS) begin
                            ms_r    <= 9'h0;
                            state_r <= ST_LOAD;
                        end
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // Stall by the UART holds the sequencer; framing per line_cfg_out is
    // left to the bit engine downstream
    srf_skid2 #(
        .WIDTH(8)
    ) u_buf (
        .sys_clk_in    (sys_clk_in),
        .sys_rst_in    (sys_rst_in),
        .in_valid_in   (state_r == ST_SEND),
        .in_data_in    (char_nxt),
        .in_ready_out  (buf_ready),
        .out_valid_out (tx_valid_out),
        .out_data_out  (tx_data_out),
        .out_ready_in  (tx_ready_in)
    );
endmodule // srf_formatter

// ==== srf_formatter_assertions.sv ====
`timescale 1ns/1ps
`include "srf_defines.vh"
module srf_formatter_assertions #(
    parameter HAS_SERIAL = 1
) (
    input wire        sys_clk_in,
    input wire        sys_rst_in,
    input wire        psel_in,
    input wire        penable_in,
    input wire        pwrite_in,
    input wire [11:0] paddr_in,
    input wire [31:0] pwdata_in,
    input wire [31:0] prdata_out,
    input wire        pready_out,
    input wire        pslverr_out,
    input wire        timer_clear_out,
    input wire [3:0]  line_cfg_out,
    input wire        tx_valid_out,
    input wire [7:0]  tx_data_out,
    input wire        tx_ready_in
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (sys_rst_in);
    sequence s_first_access;
        psel_in && penable_in && !$past(penable_in);
    endsequence
    sequence s_cmd_done;
        psel_in && penable_in && pready_out && pwrite_in && paddr_in == `SRF_ADDR_COMMAND;
    endsequence
    property p_one_wait;
        s_first_access |=> pready_out;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("pready not after one wait");
    property p_rdy_pulse;
        pready_out |=> !pready_out;
    endproperty
    a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready longer than a cycle");
    property p_err_zero;
        pslverr_out |-> pready_out && (pwrite_in || prdata_out == 32'h0000_0000);
    endproperty
    a_err_zero: assert property (p_err_zero) else $error("bad error response");
    property p_start_quiet;
        s_cmd_done ##0 (pwdata_in[1:0] != 2'h0 && !tx_valid_out) |=> !tx_valid_out [*8];
    endproperty
    a_start_quiet: assert property (p_start_quiet) else $error("report too early");
    property p_tx_hold;
        tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_data_out);
    endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("character dropped");
    property p_clr_pulse;
        timer_clear_out |=> !timer_clear_out;
    endproperty
    a_clr_pulse: assert property (p_clr_pulse) else $error("clear not a pulse");
    property p_line_legal;
        line_cfg_out <= `SRF_LINE_MAX;
    endproperty
    a_line_legal: assert property (p_line_legal) else $error("illegal line code");
    property p_restore;
        s_cmd_done ##0 pwdata_in[`SRF_CMD_RESTORE] |-> ##[1:2] line_cfg_out == `SRF_DEF_LINE;
    endproperty
    a_restore: assert property (p_restore) else $error("restore failed");
    property p_serial_only;
        HAS_SERIAL != 0 || !tx_valid_out;
    endproperty
    a_serial_only: assert property (p_serial_only) else $error("report in plain build");
endmodule // srf_formatter_assertions
bind srf_formatter srf_formatter_assertions #(.HAS_SERIAL(HAS_SERIAL)) srf_formatter_assertions_inst (
    .sys_clk_in, .sys_rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
    .prdata_out, .pready_out, .pslverr_out, .timer_clear_out, .line_cfg_out,
    .tx_valid_out, .tx_data_out, .tx_ready_in);

// ==== srf_uart_model.sv ====
`timescale 1ns/1ps
module srf_uart_model (
    input  wire logic       sys_clk_in,
    input  wire logic       sys_rst_in,
    input  wire logic       slow_in,
    input  wire logic       tx_valid_in,
    input  wire logic [7:0] tx_data_in,
    output logic            tx_ready_out
);
    logic [7:0] chars[$];
    int         stamps[$];
    int         cyc;
    logic [1:0] ph;
    always @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cyc <= 0;
            ph <= 2'h0;
            tx_ready_out <= 1'b0;
        end else begin
            cyc <= cyc + 1;
            ph <= ph + 2'h1;
            if (tx_valid_in && tx_ready_out) begin
                chars.push_back(tx_data_in);
                stamps.push_back(cyc);
            end
            // A slow line takes one character in four, like a busy shifter
            tx_ready_out <= !slow_in || ph == 2'h3;
        end
    end
endmodule // srf_uart_model

// ==== test_serial_report_formatter.sv ====
`timescale 1ns/1ps
`include "srf_defines.vh"
module test_serial_report_formatter;
    localparam int MS = 10;
    localparam int ST = 3;
    localparam int GP = 4;
    logic        sys_clk_in = 0, sys_rst_in = 1, psel_in = 0, penable_in = 0, pwrite_in = 0;
    logic [11:0] paddr_in = 12'h000;
    logic [31:0] pwdata_in = 32'h0, prdata_out, rd;
    logic        pready_out, pslverr_out, timer_clear_out, tx_valid_out, tx_ready_in, err;
    logic        user_print_in = 0, slow = 0;
    logic [23:0] timer_bcd_in = 24'h001234, preset1_bcd_in = 24'h000005;
    logic [23:0] preset2_bcd_in = 24'h120000;
    logic [3:0]  line_cfg_out;
    logic [7:0]  tx_data_out;
    int          n_fail = 0, num_checks = 0, n_clr = 0, t0;
    always #2.5 sys_clk_in = ~sys_clk_in;
    always @(posedge sys_clk_in) if (timer_clear_out === 1'b1) n_clr <= n_clr + 1;
    srf_formatter #(.HAS_SERIAL(1), .MS_CYCLES(32'd10), .START_MS(9'd3), .GAP_MS(9'd4))
    srf_formatter_inst (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .psel_in(psel_in),
        .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
        .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
        .pslverr_out(pslverr_out), .timer_bcd_in(timer_bcd_in), .preset1_bcd_in(preset1_bcd_in),
        .preset2_bcd_in(preset2_bcd_in), .user_print_in(user_print_in),
        .timer_clear_out(timer_clear_out), .line_cfg_out(line_cfg_out),
        .tx_valid_out(tx_valid_out), .tx_data_out(tx_data_out), .tx_ready_in(tx_ready_in));
    srf_uart_model srf_uart_model_inst (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
        .slow_in(slow), .tx_valid_in(tx_valid_out), .tx_data_in(tx_data_out),
        .tx_ready_out(tx_ready_in));
    task automatic fail(input string m);
        n_fail++;
        $display("ERROR at %0t: %s", $time, m);
    endtask
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string m);
        num_checks++;
        if (got !== exp) fail($sformatf("%s got %h expected %h", m, got, exp));
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string m);
        num_checks++;
        if (got !== exp) fail($sformatf("%s got %h expected %h", m, got, exp));
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk_in);
        psel_in <= 1'b1;
        pwrite_in <= wr;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge sys_clk_in);
        penable_in <= 1'b1;
        do begin
            @(posedge sys_clk_in);
        end while (pready_out !== 1'b1);
        rd = prdata_out;
        err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk32(rd, e, "register read");
    endtask
    task automatic wait_done(input int n);
        do begin
            apb(1'b0, `SRF_ADDR_STATUS, 32'h0);
        end while (rd[`SRF_ST_BUSY] !== 1'b0);
        // Idle only means the last character is queued; let the buffer drain
        while (tx_valid_out !== 1'b0) @(posedge sys_clk_in);
        chk32(srf_uart_model_inst.chars.size(), n, "character count");
    endtask
    task automatic chk_str(input string s, input int from);
        for (int i = 0; i < s.len(); i++)
            chk8(srf_uart_model_inst.chars[from + i], s[i], s);
    endtask
    task automatic start(input logic [31:0] cfg, input logic [31:0] cmd);
        srf_uart_model_inst.chars.delete();
        srf_uart_model_inst.stamps.delete();
        apb(1'b1, `SRF_ADDR_CONFIG, cfg);
        if (cmd != 32'h0) apb(1'b1, `SRF_ADDR_COMMAND, cmd);
        t0 = srf_uart_model_inst.cyc;
    endtask
    task automatic t_regs();
        rdchk(`SRF_ADDR_CONFIG, 32'h0000_9300);
        chk32({28'h0, line_cfg_out}, 32'h9, "line code");
        apb(1'b0, 12'h00C, 32'h0);
        chk32({err, rd[30:0]}, 32'h8000_0000, "unmapped read");
        apb(1'b1, `SRF_ADDR_CONFIG, 32'h0000_B32A);
        apb(1'b1, `SRF_ADDR_CONFIG, 32'h0000_C364);
        rdchk(`SRF_ADDR_CONFIG, 32'h0000_B32A);
        chk32({28'h0, line_cfg_out}, 32'hB, "line code");
        apb(1'b1, `SRF_ADDR_COMMAND, 32'h0000_000E);
        rdchk(`SRF_ADDR_STATUS, 32'h0000_0008);
        apb(1'b1, `SRF_ADDR_STATUS, 32'h0000_0008);
        rdchk(`SRF_ADDR_STATUS, 32'h0000_0000);
    endtask
    task automatic t_xmit();
        start(32'h0000_932A, 32'h0000_0002);
        wait_done(15);
        chk_str("42 TMR   1234\r\n", 0);
        t0 = srf_uart_model_inst.stamps[0] - t0;
        chk32({31'h0, t0 >= ST * MS && t0 <= ST * MS + 15}, 32'h1, "start delay");
        chk32(n_clr, 32'h0, "clear on transmit");
    endtask
    task automatic t_print_verbose();
        slow <= 1'b1;
        start(32'h0000_9607, 32'h0000_0001);
        wait_done(30);
        chk_str("07 P1       5\r\n", 0);
        chk_str("07 P2  120000\r\n", 15);
        t0 = srf_uart_model_inst.stamps[15] - srf_uart_model_inst.stamps[14];
        chk32({31'h0, t0 >= GP * MS}, 32'h1, "value pause");
        chk32(n_clr, 32'h0, "clear without timer");
        slow <= 1'b0;
    endtask
    task automatic t_user_terse();
        int k;
        start(32'h0000_9780, 32'h0);
        user_print_in <= 1'b1;
        for (k = 0; k < 200 && srf_uart_model_inst.chars.size() == 0; k++)
            @(posedge sys_clk_in);
        user_print_in <= 1'b0;
        wait_done(24);
        chk_str("  1234\r\n", 0);
        chk_str("     5\r\n120000\r\n", 8);
        t0 = srf_uart_model_inst.stamps[8] - srf_uart_model_inst.stamps[7];
        chk32({31'h0, t0 < GP * MS}, 32'h1, "terse pause");
        chk32(n_clr, 32'h1, "clear after print");
    endtask
    task automatic t_restore();
        start(32'h0000_9180, 32'h0000_0001);
        wait_done(8);
        chk_str("  1234\r\n", 0);
        chk32(n_clr, 32'h1, "clear option off");
        apb(1'b1, `SRF_ADDR_COMMAND, 32'h0000_0100);
        rdchk(`SRF_ADDR_CONFIG, 32'h0000_9300);
        chk32({28'h0, line_cfg_out}, 32'h9, "line code");
    endtask
    task automatic close_out();
        $display("Checks: %0d, mismatches: %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        #300000;
        fail("watchdog expired");
        close_out();
    end
    initial begin
        repeat (10) @(posedge sys_clk_in);
        sys_rst_in <= 1'b0;
        t_regs();
        t_xmit();
        t_print_verbose();
        t_user_terse();
        t_restore();
        close_out();
    end
endmodule // test_serial_report_formatter
